//--- pkg/fhts_pkg.sv
// Summary of operation
// R1: Suppress blocks retune, address still advances
// R2: Suppress honoured only in sequential addressing
// R3: Clear returns sequence address to zero
// R4: Clear sampled always, applied at step
// R5: Analyzer edge retunes in external, enabled, armed
// R6: Controller gives valid index per analyzer edge
// R7: Generator edge retunes in external, enabled, armed
// R8: Controller gives valid index per generator edge
// R9: Step trigger advances only in sequential mode
// R10: Step retunes only enabled, armed units
// R11: Optional generator level pulse-off per hop
// R12: Jump pulse on non-increment step or clear
// R13: Index lines unsigned binary, high is one
// R14: Same-type triggers spaced 577 us apart; the testbench spaces them about 4 us apart
// R15: Analyzer skips retune when frequency unchanged
// R16: Inputs synchronised, rising edges single-cycle
package fhts_pkg;

	localparam int INDEX_W = 11;
	localparam int CNT_W = 8;
	localparam int SYNC_STAGES = 2;

	localparam int CLK_PERIOD_NS = 10;
	// Pulse widths on the connector are at least 1 us
	localparam int JUMP_PULSE_NS = 1000;
	localparam int GEN_OFF_PULSE_NS = 1000;
	localparam int TRIG_SPACING_US = 577;

	localparam int JUMP_PULSE_CYCLES = (JUMP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GEN_OFF_CYCLES = (GEN_OFF_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [INDEX_W-1:0] INDEX_RESET = 11'h000;
	localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
	localparam logic [CNT_W-1:0] JUMP_LOAD = CNT_W'(JUMP_PULSE_CYCLES);
	localparam logic [CNT_W-1:0] GEN_OFF_LOAD = CNT_W'(GEN_OFF_CYCLES);

endpackage : fhts_pkg

//--- hdl/fhts_sync.sv
`timescale 1ns/1ps
module fhts_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [W-1:0] d_i,
	input wire logic [W-1:0] rst_val_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] stage1;
		logic [W-1:0] stage2;
	} fhts_sync_state_t;

	fhts_sync_state_t st_reg;
	fhts_sync_state_t st_next;

	always_comb begin
		st_next = st_reg;
		if (ce_i) begin
			st_next.stage1 = d_i;
			// First stage feeds only the second
			st_next.stage2 = st_reg.stage1;
		end
	end

	// Reset value is a constant tie at every instance
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q_o = st_reg.stage2 ^ rst_val_i;

endmodule : fhts_sync

//--- hdl/fhts_edge.sv
`timescale 1ns/1ps
module fhts_edge (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic level_i,
	output logic rise_o
);
	typedef struct packed {
		logic prev;
		logic rise;
	} fhts_edge_state_t;

	fhts_edge_state_t st_reg;
	fhts_edge_state_t st_next;

	always_comb begin
		st_next = st_reg;
		if (ce_i) begin
			st_next.prev = level_i;
			st_next.rise = level_i & ~st_reg.prev;
		end
	end

	// Prev starts high so a line already high at reset is no edge
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= '{prev: 1'b1, rise: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign rise_o = st_reg.rise & ce_i;

endmodule : fhts_edge

//--- hdl/fhts_top.sv
`timescale 1ns/1ps
module fhts_top (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic CE_I,
	input wire logic GENERATOR_HOP_TRIGGER_I,
	input wire logic ANALYZER_HOP_TRIGGER_I,
	input wire logic SEQUENCE_STEP_TRIGGER_I,
	input wire logic SEQUENCE_CLEAR_N_I,
	input wire logic HOP_SUPPRESS_N_I,
	input wire logic [fhts_pkg::INDEX_W-1:0] HOP_TABLE_INDEX_I,
	input wire logic ADDR_SRC_SEQ_I,
	input wire logic GEN_HOP_EN_I,
	input wire logic GEN_HOP_ARM_I,
	input wire logic ANA_HOP_EN_I,
	input wire logic ANA_HOP_ARM_I,
	input wire logic GEN_PULSE_ON_HOP_I,
	input wire logic [fhts_pkg::INDEX_W-1:0] SEQ_TABLE_LAST_I,
	input wire logic ANA_NEXT_SAME_I,
	output logic GEN_RETUNE_O,
	output logic [fhts_pkg::INDEX_W-1:0] GEN_INDEX_O,
	output logic ANA_RETUNE_O,
	output logic [fhts_pkg::INDEX_W-1:0] ANA_INDEX_O,
	output logic GEN_PULSE_OFF_O,
	output logic SEQ_JUMP_O,
	output logic [fhts_pkg::INDEX_W-1:0] SEQ_ADDR_O,
	output logic [fhts_pkg::INDEX_W-1:0] SEQ_NEXT_ADDR_O
);
	localparam int IW = fhts_pkg::INDEX_W;
	localparam int NLVL = 5;

	//------------------------------------------------------------
	// Reset release and input synchronisers
	//------------------------------------------------------------
	logic rst_n;
	logic [NLVL-1:0] lvl_s;
	logic [IW-1:0] idx_s;
	logic gen_trig_s;
	logic ana_trig_s;
	logic step_trig_s;
	logic clear_n_s;
	logic suppress_n_s;
	logic gen_rise;
	logic ana_rise;
	logic step_rise;
	logic edge_rst_n;

	fhts_sync #(.W(1)) u_rst_sync (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.ce_i(1'b1),
		.d_i(1'b1),
		.rst_val_i(1'b0),
		.q_o(rst_n)
	);

	// R16: two-flop sync
	// Active-low lines are inverted around the sync so they idle high out of reset
	fhts_sync #(.W(NLVL)) u_lvl_sync (
		.clk_i(CLK_I),
		.rst_n_i(rst_n),
		.ce_i(CE_I),
		.d_i({GENERATOR_HOP_TRIGGER_I, ANALYZER_HOP_TRIGGER_I, SEQUENCE_STEP_TRIGGER_I,
			~SEQUENCE_CLEAR_N_I, ~HOP_SUPPRESS_N_I}),
		.rst_val_i(5'h03),
		.q_o(lvl_s)
	);

	assign gen_trig_s = lvl_s[4];
	assign ana_trig_s = lvl_s[3];
	assign step_trig_s = lvl_s[2];
	assign clear_n_s = lvl_s[1];
	assign suppress_n_s = lvl_s[0];

	// R13: unsigned index
	// Index goes through the same two stages as the triggers, so it
	// lines up with the edge pulse given 1 us of setup on the pins
	fhts_sync #(.W(IW)) u_idx_sync (
		.clk_i(CLK_I),
		.rst_n_i(rst_n),
		.ce_i(CE_I),
		.d_i(HOP_TABLE_INDEX_I),
		.rst_val_i(11'h000),
		.q_o(idx_s)
	);

	// R16: edge reset
	// Edge detectors leave reset only once the level syncs hold real pin
	// values, so a trigger already high at reset is not taken as an edge
	fhts_sync #(.W(1)) u_edge_rst_sync (
		.clk_i(CLK_I),
		.rst_n_i(rst_n),
		.ce_i(CE_I),
		.d_i(1'b1),
		.rst_val_i(1'b0),
		.q_o(edge_rst_n)
	);

	// R16: edge pulses
	fhts_edge u_gen_edge (
		.clk_i(CLK_I),
		.rst_n_i(edge_rst_n),
		.ce_i(CE_I),
		.level_i(gen_trig_s),
		.rise_o(gen_rise)
	);

	fhts_edge u_ana_edge (
		.clk_i(CLK_I),
		.rst_n_i(edge_rst_n),
		.ce_i(CE_I),
		.level_i(ana_trig_s),
		.rise_o(ana_rise)
	);

	fhts_edge u_step_edge (
		.clk_i(CLK_I),
		.rst_n_i(edge_rst_n),
		.ce_i(CE_I),
		.level_i(step_trig_s),
		.rise_o(step_rise)
	);

	//------------------------------------------------------------
	// Hop state
	//------------------------------------------------------------
	typedef struct packed {
		logic clr_pend;
		logic [IW-1:0] seq_addr;
		logic [IW-1:0] nxt_addr;
		logic gen_retune;
		logic [IW-1:0] gen_index;
		logic ana_retune;
		logic [IW-1:0] ana_index;
		logic [fhts_pkg::CNT_W-1:0] off_cnt;
		logic gen_off;
		logic [fhts_pkg::CNT_W-1:0] jump_cnt;
		logic jump;
	} fhts_top_state_t;

	fhts_top_state_t st_reg;
	fhts_top_state_t st_next;

	logic seq_mode;
	logic gen_ok;
	logic ana_ok;
	logic suppress;
	logic step_ev;
	logic wrap;
	logic jump_ev;
	logic gen_ext_ev;
	logic ana_ext_ev;
	logic gen_seq_ev;
	logic ana_seq_ev;
	logic gen_ev;
	logic [IW-1:0] step_addr;

	always_comb begin
		seq_mode = ADDR_SRC_SEQ_I;
		gen_ok = GEN_HOP_EN_I & GEN_HOP_ARM_I;
		ana_ok = ANA_HOP_EN_I & ANA_HOP_ARM_I;
		// R2: suppress in sequential only
		suppress = seq_mode & ~suppress_n_s;
		// R9: step only in sequential
		step_ev = seq_mode & step_rise;
		wrap = (st_reg.seq_addr == SEQ_TABLE_LAST_I);
		// R3: clear goes to zero
		step_addr = (st_reg.clr_pend | wrap) ? fhts_pkg::INDEX_RESET : st_reg.seq_addr + 11'h001;
		// R12: jump on non-increment
		jump_ev = step_ev & (st_reg.clr_pend | wrap);
		// R7: generator external hop
		gen_ext_ev = ~seq_mode & gen_rise & gen_ok;
		// R5: analyzer external hop
		ana_ext_ev = ~seq_mode & ana_rise & ana_ok;
		// R10: step retunes enabled units
		// R1: suppress gates retune only
		gen_seq_ev = step_ev & gen_ok & ~suppress;
		// R15: skip unchanged analyzer
		ana_seq_ev = step_ev & ana_ok & ~suppress & ~ANA_NEXT_SAME_I;
		gen_ev = gen_ext_ev | gen_seq_ev;
	end

	always_comb begin
		st_next = st_reg;
		if (CE_I) begin
			// R4: clear latched, applied at step
			// A low clear seen in the step cycle stays pending for the next step
			st_next.clr_pend = ~clear_n_s | (st_reg.clr_pend & ~step_ev);
			// R1: address advances regardless
			if (step_ev) begin
				st_next.seq_addr = step_addr;
			end
			// Lags the address by a cycle; steps are hundreds of us apart
			st_next.nxt_addr = step_addr;
			st_next.gen_retune = gen_ev;
			st_next.ana_retune = ana_ext_ev | ana_seq_ev;
			if (gen_ext_ev) begin
				st_next.gen_index = idx_s;
			end else if (gen_seq_ev) begin
				st_next.gen_index = step_addr;
			end
			if (ana_ext_ev) begin
				st_next.ana_index = idx_s;
			end else if (ana_seq_ev) begin
				st_next.ana_index = step_addr;
			end
			// R11: generator pulse-off
			if (gen_ev & GEN_PULSE_ON_HOP_I) begin
				st_next.off_cnt = fhts_pkg::GEN_OFF_LOAD;
				st_next.gen_off = 1'b1;
			end else if (st_reg.off_cnt > 8'h01) begin
				st_next.off_cnt = st_reg.off_cnt - 8'h01;
			end else begin
				st_next.off_cnt = fhts_pkg::CNT_RESET;
				st_next.gen_off = 1'b0;
			end
			// R12: stretched jump pulse
			if (jump_ev) begin
				st_next.jump_cnt = fhts_pkg::JUMP_LOAD;
				st_next.jump = 1'b1;
			end else if (st_reg.jump_cnt > 8'h01) begin
				st_next.jump_cnt = st_reg.jump_cnt - 8'h01;
			end else begin
				st_next.jump_cnt = fhts_pkg::CNT_RESET;
				st_next.jump = 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign GEN_RETUNE_O = st_reg.gen_retune;
	assign GEN_INDEX_O = st_reg.gen_index;
	assign ANA_RETUNE_O = st_reg.ana_retune;
	assign ANA_INDEX_O = st_reg.ana_index;
	assign GEN_PULSE_OFF_O = st_reg.gen_off;
	assign SEQ_JUMP_O = st_reg.jump;
	assign SEQ_ADDR_O = st_reg.seq_addr;
	assign SEQ_NEXT_ADDR_O = st_reg.nxt_addr;

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------
	sequence s_gen_ext;
		!ADDR_SRC_SEQ_I && gen_rise && GEN_HOP_EN_I && GEN_HOP_ARM_I;
	endsequence

	sequence s_seq_step;
		ADDR_SRC_SEQ_I && step_rise;
	endsequence

	AST_GEN_EXT: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I) // R7
		s_gen_ext |=> GEN_RETUNE_O && GEN_INDEX_O == $past(idx_s))
		else $error("generator external hop missed");

	AST_ANA_EXT: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I) // R5
		(!ADDR_SRC_SEQ_I && ana_rise && !(ANA_HOP_EN_I && ANA_HOP_ARM_I)) |=> !ANA_RETUNE_O)
		else $error("analyzer retuned while not armed");

	AST_SUPPRESS_EXT: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I) // R2
		(s_gen_ext and !suppress_n_s) |=> GEN_RETUNE_O)
		else $error("suppress acted in external mode");

	AST_SUPPRESS_SEQ: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I) // R1
		(s_seq_step and !suppress_n_s and !st_reg.clr_pend and !wrap)
		|=> !GEN_RETUNE_O && !ANA_RETUNE_O && SEQ_ADDR_O == $past(SEQ_ADDR_O) + 11'h001)
		else $error("suppressed step retuned or failed to advance");

	AST_STEP_IGNORED: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I) // R9
		!(ADDR_SRC_SEQ_I && step_rise) |=> $stable(SEQ_ADDR_O))
		else $error("sequence address moved without a step");

	AST_CLEAR_STEP: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I) // R4
		(s_seq_step and st_reg.clr_pend) |=> SEQ_ADDR_O == 11'h000 && SEQ_JUMP_O)
		else $error("pending clear not applied at step");

	AST_CLEAR_LATCH: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I) // R4
		!clear_n_s |=> st_reg.clr_pend)
		else $error("clear not latched");

	AST_JUMP_WIDTH: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I) // R12
		jump_ev |=> SEQ_JUMP_O [*8])
		else $error("jump pulse too short");

	AST_GEN_OFF: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I) // R11
		(gen_ev && GEN_PULSE_ON_HOP_I) |=> GEN_PULSE_OFF_O [*8])
		else $error("generator pulse-off missing");

	AST_ANA_SKIP: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I) // R15
		(s_seq_step and ANA_NEXT_SAME_I) |=> !ANA_RETUNE_O && $stable(ANA_INDEX_O))
		else $error("analyzer retuned to same frequency");

	AST_ANA_SEQ: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I) // R10
		(s_seq_step and suppress_n_s and ANA_HOP_EN_I and ANA_HOP_ARM_I
			and !ANA_NEXT_SAME_I) |=> ANA_RETUNE_O && ANA_INDEX_O == SEQ_ADDR_O)
		else $error("sequence step did not retune analyzer");

	AST_CLEAR_NEXT: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I) // R4
		st_reg.clr_pend |=> SEQ_NEXT_ADDR_O == 11'h000)
		else $error("next address ignores pending clear");

	AST_SEQ_RETUNE: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I) // R10
		(s_seq_step and suppress_n_s and GEN_HOP_EN_I and GEN_HOP_ARM_I)
		|=> GEN_RETUNE_O && GEN_INDEX_O == SEQ_ADDR_O)
		else $error("sequence step did not retune generator");

endmodule : fhts_top

//--- test/fhts_ctrl_model.sv
`timescale 1ns/1ps
module fhts_ctrl_model #(
	parameter int GAP_CYC = 57700
) (
	input wire logic clk_i,
	output logic gen_trig_o,
	output logic ana_trig_o,
	output logic step_trig_o,
	output logic clear_n_o,
	output logic suppress_n_o,
	output logic [fhts_pkg::INDEX_W-1:0] index_o
);
	// Pulse widths and index setup/hold of 1 us
	localparam int W_CYC = 100;

	initial begin
		gen_trig_o = 1'b0;
		ana_trig_o = 1'b0;
		step_trig_o = 1'b0;
		clear_n_o = 1'b1;
		suppress_n_o = 1'b1;
		index_o = 11'h000;
	end

	task automatic hop(input logic [1:0] kind, input logic [fhts_pkg::INDEX_W-1:0] idx);
		@(posedge clk_i);
		index_o <= idx;
		repeat (W_CYC) @(posedge clk_i);
		case (kind)
			2'h0: gen_trig_o <= 1'b1;
			2'h1: ana_trig_o <= 1'b1;
			default: step_trig_o <= 1'b1;
		endcase
		repeat (W_CYC) @(posedge clk_i);
		gen_trig_o <= 1'b0;
		ana_trig_o <= 1'b0;
		step_trig_o <= 1'b0;
		repeat (W_CYC) @(posedge clk_i);
		// Lines released: show a wrong value, not the old one
		index_o <= ~idx;
		repeat (GAP_CYC) @(posedge clk_i);
	endtask : hop

	task automatic set_sup(input logic v);
		@(posedge clk_i);
		suppress_n_o <= v;
	endtask : set_sup

	task automatic set_clr(input logic v);
		@(posedge clk_i);
		clear_n_o <= v;
	endtask : set_clr

	task automatic clear();
		@(posedge clk_i);
		clear_n_o <= 1'b0;
		repeat (W_CYC) @(posedge clk_i);
		clear_n_o <= 1'b1;
		repeat (W_CYC) @(posedge clk_i);
	endtask : clear
endmodule : fhts_ctrl_model

//--- test/test_fhts_top.sv
`timescale 1ns/1ps
module test_fhts_top;
	typedef struct packed {
		logic seq;
		logic [1:0] kind;
		logic [3:0] cfg;
		logic sup_n;
		logic [10:0] idx;
		logic eg;
		logic ea;
		logic ej;
		logic [10:0] addr;
	} fhts_row_t;
	// kind 0 generator, 1 analyzer, 2 step; cfg is gen en/arm, ana en/arm
	localparam fhts_row_t ROWS [16] = '{
		'{1'h0, 2'h0, 4'hF, 1'h1, 11'h5A5, 1'h1, 1'h0, 1'h0, 11'h000},
		'{1'h0, 2'h1, 4'hF, 1'h1, 11'h7FF, 1'h0, 1'h1, 1'h0, 11'h000},
		'{1'h0, 2'h0, 4'h7, 1'h1, 11'h001, 1'h0, 1'h0, 1'h0, 11'h000},
		'{1'h0, 2'h0, 4'hB, 1'h1, 11'h002, 1'h0, 1'h0, 1'h0, 11'h000},
		'{1'h0, 2'h1, 4'hE, 1'h1, 11'h003, 1'h0, 1'h0, 1'h0, 11'h000},
		'{1'h0, 2'h1, 4'hD, 1'h1, 11'h004, 1'h0, 1'h0, 1'h0, 11'h000},
		'{1'h0, 2'h2, 4'hF, 1'h1, 11'h005, 1'h0, 1'h0, 1'h0, 11'h000},
		'{1'h1, 2'h0, 4'hF, 1'h1, 11'h006, 1'h0, 1'h0, 1'h0, 11'h000},
		'{1'h1, 2'h1, 4'hF, 1'h1, 11'h007, 1'h0, 1'h0, 1'h0, 11'h000},
		'{1'h1, 2'h2, 4'hF, 1'h1, 11'h2AA, 1'h1, 1'h1, 1'h0, 11'h001},
		'{1'h1, 2'h2, 4'hC, 1'h1, 11'h2AA, 1'h1, 1'h0, 1'h0, 11'h002},
		'{1'h1, 2'h2, 4'h3, 1'h1, 11'h2AA, 1'h0, 1'h1, 1'h0, 11'h003},
		'{1'h1, 2'h2, 4'hF, 1'h0, 11'h2AA, 1'h0, 1'h0, 1'h1, 11'h000},
		'{1'h1, 2'h2, 4'hF, 1'h0, 11'h2AA, 1'h0, 1'h0, 1'h0, 11'h001},
		'{1'h0, 2'h0, 4'hF, 1'h0, 11'h123, 1'h1, 1'h0, 1'h0, 11'h001},
		'{1'h1, 2'h2, 4'hF, 1'h1, 11'h2AA, 1'h1, 1'h1, 1'h0, 11'h002}
	};
	logic clk, rst_n, seq_src, gen_en, gen_arm, ana_en, ana_arm, pulse_on, ana_same, ce;
	logic gtrg, atrg, strg, clr_n, sup_n, gen_rt, ana_rt, goff, jump, jump_q;
	logic [10:0] idx, gen_ix, ana_ix, addr, nxt;
	logic [15:0] gen_cnt, ana_cnt, jump_cnt, off_cnt, g0, a0, j0, o0;
	int bad_count, checked;
	fhts_row_t r;

	fhts_ctrl_model #(.GAP_CYC(100)) fhts_ctrl_model_i (.clk_i(clk), .gen_trig_o(gtrg),
		.ana_trig_o(atrg), .step_trig_o(strg), .clear_n_o(clr_n), .suppress_n_o(sup_n),
		.index_o(idx));
	fhts_top fhts_top_i (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
		.GENERATOR_HOP_TRIGGER_I(gtrg), .ANALYZER_HOP_TRIGGER_I(atrg),
		.SEQUENCE_STEP_TRIGGER_I(strg), .SEQUENCE_CLEAR_N_I(clr_n), .HOP_SUPPRESS_N_I(sup_n),
		.HOP_TABLE_INDEX_I(idx), .ADDR_SRC_SEQ_I(seq_src), .GEN_HOP_EN_I(gen_en),
		.GEN_HOP_ARM_I(gen_arm), .ANA_HOP_EN_I(ana_en), .ANA_HOP_ARM_I(ana_arm),
		.GEN_PULSE_ON_HOP_I(pulse_on), .SEQ_TABLE_LAST_I(11'h003), .ANA_NEXT_SAME_I(ana_same),
		.GEN_RETUNE_O(gen_rt), .GEN_INDEX_O(gen_ix), .ANA_RETUNE_O(ana_rt),
		.ANA_INDEX_O(ana_ix), .GEN_PULSE_OFF_O(goff), .SEQ_JUMP_O(jump), .SEQ_ADDR_O(addr),
		.SEQ_NEXT_ADDR_O(nxt));

	always #5 clk = ~clk;

	// Event counters, so one-cycle pulses are never missed between checks
	always @(posedge clk) begin
		jump_q <= jump;
		if (gen_rt === 1'b1) gen_cnt <= gen_cnt + 16'h0001;
		if (ana_rt === 1'b1) ana_cnt <= ana_cnt + 16'h0001;
		if (jump === 1'b1 && jump_q !== 1'b1) jump_cnt <= jump_cnt + 16'h0001;
		if (goff === 1'b1) off_cnt <= off_cnt + 16'h0001;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic stop_test();
		if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test

	task automatic mark();
		g0 = gen_cnt;
		a0 = ana_cnt;
		j0 = jump_cnt;
		o0 = off_cnt;
	endtask : mark

	initial begin
		repeat (90000) @(posedge clk);
		bad_count++;
		stop_test();
	end

	initial begin
		{clk, rst_n, seq_src, gen_en, gen_arm, ana_en, ana_arm, pulse_on, ana_same} = 9'h000;
		{gen_cnt, ana_cnt, jump_cnt, off_cnt, jump_q} = 65'h0;
		ce = 1'b1;
		bad_count = 0;
		checked = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk);
		for (int i = 0; i < 16; i++) begin
			r = ROWS[i];
			@(posedge clk);
			seq_src <= r.seq;
			{gen_en, gen_arm, ana_en, ana_arm} <= r.cfg;
			fhts_ctrl_model_i.set_sup(r.sup_n);
			repeat (10) @(posedge clk);
			mark();
			fhts_ctrl_model_i.hop(r.kind, r.idx);
			chk(gen_cnt - g0, {15'h0000, r.eg});
			chk(ana_cnt - a0, {15'h0000, r.ea});
			if (r.eg) chk({5'h00, gen_ix}, {5'h00, r.seq ? r.addr : r.idx});
			if (r.ea) chk({5'h00, ana_ix}, {5'h00, r.seq ? r.addr : r.idx});
			chk({5'h00, addr}, {5'h00, r.addr});
			chk({5'h00, nxt}, {5'h00, (r.addr == 11'h003) ? 11'h000 : r.addr + 11'h001});
			chk(jump_cnt - j0, {15'h0000, r.ej});
			chk(off_cnt - o0, 16'h0000);
		end
		// Clear waits for the next step, then restarts at zero
		fhts_ctrl_model_i.clear();
		chk({5'h00, addr}, 16'h0002);
		chk({5'h00, nxt}, 16'h0000);
		mark();
		fhts_ctrl_model_i.hop(2'h2, 11'h2AA);
		chk({5'h00, addr}, 16'h0000);
		chk({5'h00, gen_ix}, 16'h0000);
		chk(jump_cnt - j0, 16'h0001);
		// Analyzer stays put when the next entry is the same frequency
		ana_same <= 1'b1;
		mark();
		fhts_ctrl_model_i.hop(2'h2, 11'h2AA);
		chk(ana_cnt - a0, 16'h0000);
		chk(gen_cnt - g0, 16'h0001);
		// Clear held low through steps: reset-and-hold at zero, a jump each step
		ana_same <= 1'b0;
		fhts_ctrl_model_i.set_clr(1'b0);
		mark();
		fhts_ctrl_model_i.hop(2'h2, 11'h2AA);
		fhts_ctrl_model_i.hop(2'h2, 11'h2AA);
		chk({5'h00, addr}, 16'h0000);
		chk({5'h00, gen_ix}, 16'h0000);
		chk(jump_cnt - j0, 16'h0002);
		fhts_ctrl_model_i.set_clr(1'b1);
		// Generator level pulse-off per hop
		seq_src <= 1'b0;
		pulse_on <= 1'b1;
		mark();
		fhts_ctrl_model_i.hop(2'h0, 11'h400);
		chk(off_cnt - o0, 16'h0064);
		// Clock enable low freezes all but the reset sync, so an edge in that time is lost
		ce <= 1'b0;
		mark();
		fhts_ctrl_model_i.hop(2'h0, 11'h155);
		ce <= 1'b1;
		chk(gen_cnt - g0, 16'h0000);
		chk({5'h00, gen_ix}, 16'h0400);
		chk(off_cnt - o0, 16'h0000);
		// Mid-run reset clears the sequence state at once
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk({5'h00, addr}, 16'h0000);
		chk({5'h00, gen_ix}, 16'h0000);
		// Second release: no false edge, then stepping resumes from zero
		rst_n <= 1'b1;
		seq_src <= 1'b1;
		pulse_on <= 1'b0;
		mark();
		repeat (10) @(posedge clk);
		chk(gen_cnt - g0, 16'h0000);
		fhts_ctrl_model_i.hop(2'h2, 11'h2AA);
		chk({5'h00, addr}, 16'h0001);
		chk({5'h00, ana_ix}, 16'h0001);
		chk({5'h00, nxt}, 16'h0002);
		stop_test();
	end
endmodule : test_fhts_top
